// File: src/abd_pkg.sv
// Purpose: Shared constants for the auto-baud detector block
// Assumes: Register bus is classic Wishbone, 32-bit data, word aligned
// Notes: Offsets are byte addresses
package abd_pkg;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_DIV = 4'h4;
  localparam logic [3:0] ADDR_RXDATA = 4'h8;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'hc;
  // Mask bits sit above the status bits in the same word
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;
  // Control register bits
  localparam int CTRL_AUTOBAUD_ENABLE = 0;
  localparam int CTRL_WUE = 1;
  localparam int CTRL_WIDE_DIVISOR_SELECT = 2;
  localparam int CTRL_HIGH_SPEED_SELECT = 3;
  localparam int CTRL_OVF = 4;
  localparam int CTRL_IDLE = 5;
  // Interrupt status / mask bits
  localparam int IRQ_RX = 0;
  localparam int IRQ_OVF = 1;
  localparam int IRQ_W = 2;
  localparam int EDGES_TO_DONE = 5;
  localparam logic [15:0] COUNT_START = 16'h0001;
  // Base clock prescale values (oscillator cycles per base tick)
  localparam logic [9:0] PRE_SLOW = 10'h040;
  localparam logic [9:0] PRE_MID = 10'h010;
  localparam logic [9:0] PRE_FAST = 10'h004;
  localparam logic [9:0] ABD_MULT = 10'h008;
endpackage

// File: src/rx_sync.sv
// Purpose: Two-flop synchroniser with rising and falling edge pulses
// Assumes: Input is asynchronous to clk_i
// Notes: The first flop feeds only the second
`timescale 1ns/1ps
`default_nettype none
module rx_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rx_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  logic meta;
  logic sync;
  logic prev;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= 1'b1;
      sync <= 1'b1;
      prev <= 1'b1;
    end else begin
      meta <= rx_i;
      sync <= meta;
      prev <= sync;
    end
  end
  assign level_o = sync;
  assign rise_o = sync & ~prev;
  assign fall_o = ~sync & prev;
endmodule // rx_sync
`default_nettype wire

// File: src/abd_prescaler.sv
// Purpose: Auto-baud counter tick from the oscillator clock
// Assumes: clk_i is the oscillator
// Notes: Ratio chosen from speed bits, times eight for measurement
`timescale 1ns/1ps
`default_nettype none
module abd_prescaler (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic wide_i,
  input wire logic fast_i,
  output logic tick_o
);
  logic [9:0] base;
  logic [9:0] limit;
  logic [9:0] cnt;
  always_comb begin
    unique case ({wide_i, fast_i})
      2'b00: base = abd_pkg::PRE_SLOW;
      2'b11: base = abd_pkg::PRE_FAST;
      default: base = abd_pkg::PRE_MID;
    endcase
  end
  // Oscillator/512, /128 or /32 while measuring
  assign limit = 10'(base * abd_pkg::ABD_MULT);
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt <= '0;
    end else if (cnt == limit - 10'h001) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 10'h001;
    end
  end
  assign tick_o = run_i && (cnt == limit - 10'h001);
endmodule // abd_prescaler
`default_nettype wire

// File: src/uart_auto_baud_detect.sv
// Purpose: Auto-baud detection of a 55h sync character on the rx line
// Assumes: clk_i is the oscillator; rx_i is asynchronous
// Notes: Normal reception and break handling live outside this block
//
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Setting autobaud_enable starts calibration and holds receive idle.
// - Edges of the rx line time the divisor counter during measurement.
// - Counting starts at the first rising edge after the start bit.
// - At the fifth rising edge the count stays, enable clears, flag sets.
// - Reading the receive data register clears the receive flag.
// - Both divisor bytes form one 16-bit counter during measurement.
// - The counter advances at one eighth of the base clock rate.
// - Base clock is osc/64, osc/16 or osc/4 by the two speed bits.
// - Measurement clock is osc/512, osc/128 or osc/32 likewise.
// - The counter starts at one; software subtracts one afterwards.
// - With wake-on-break also set, measurement waits out the break.
// - Counter overflow sets overflow and receive flag, counting goes on.
// - receive_idle reads 0 while measuring and 1 at the fifth edge.
module uart_auto_baud_detect #(
  parameter int EDGES = abd_pkg::EDGES_TO_DONE
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rx_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic rx_hold_idle_o,
  output logic irq_o
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BREAK = 2'b01,
    ST_START = 2'b10,
    ST_COUNT = 2'b11
  } abd_state_e;

  abd_state_e state;
  logic rx_level;
  logic rx_rise;
  logic rx_fall;
  logic tick;
  logic autobaud_enable;
  logic wake_on_break_enable;
  logic wide_divisor_select;
  logic high_speed_select;
  logic autobaud_overflow;
  logic receive_idle;
  logic receive_flag;
  logic [15:0] divisor_pair;
  logic [2:0] edges;
  logic [abd_pkg::IRQ_W-1:0] irq_stat;
  logic [abd_pkg::IRQ_W-1:0] irq_mask;
  logic [abd_pkg::IRQ_W-1:0] irq_evt;
  logic [7:0] receive_data_reg;
  logic req;
  logic wr;
  logic rd;
  logic done;
  logic ovf_evt;
  logic clr_flag;
  logic count_run;
  logic sel_ctrl;
  logic sel_div;
  logic sel_rx;
  logic sel_stat;
  logic abd_go;
  logic abd_stop;
  logic [31:0] next_rd_data;

  // The edge counter is three bits wide
  if (EDGES < 2 || EDGES > 7) begin : g_bad_edges
    $error("EDGES must lie between 2 and 7");
  end

  rx_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rx_i(rx_i),
    .level_o(rx_level),
    .rise_o(rx_rise),
    .fall_o(rx_fall)
  );

  abd_prescaler u_pre (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(count_run),
    .wide_i(wide_divisor_select),
    .fast_i(high_speed_select),
    .tick_o(tick)
  );

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign rd = req && !wb_we_i;
  assign done = (state == ST_COUNT) && rx_rise
    && (edges == 3'(EDGES - 1));
  assign ovf_evt = (state == ST_COUNT) && tick && (divisor_pair == 16'hffff);
  assign clr_flag = rd && sel_rx;
  assign count_run = state == ST_COUNT;
  // Register selects shared by the write paths and the data-read flag clear
  assign sel_ctrl = wb_adr_i == abd_pkg::ADDR_CTRL;
  assign sel_div = wb_adr_i == abd_pkg::ADDR_DIV;
  assign sel_rx = wb_adr_i == abd_pkg::ADDR_RXDATA;
  assign sel_stat = wb_adr_i == abd_pkg::ADDR_IRQ_STAT;
  assign abd_go = wr && sel_ctrl && wb_dat_i[abd_pkg::CTRL_AUTOBAUD_ENABLE];
  assign abd_stop = wr && sel_ctrl && !wb_dat_i[abd_pkg::CTRL_AUTOBAUD_ENABLE];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // Sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (autobaud_enable) begin
            state <= wake_on_break_enable ? ST_BREAK : ST_START;
          end
        end
        ST_BREAK: begin
          // Break ends on its rising edge; the sync byte follows
          if (rx_rise) begin
            state <= ST_START;
          end
        end
        ST_START: begin
          if (rx_rise) begin
            state <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (done) begin
            state <= ST_IDLE;
          end
        end
      endcase
      if (!autobaud_enable && state != ST_IDLE) begin
        state <= ST_IDLE;
      end
    end
  end

  // Rising-edge count of the sync character; the first rise counts one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edges <= '0;
    end else if (state == ST_START && rx_rise) begin
      edges <= 3'h1;
    end else if (count_run && rx_rise) begin
      edges <= edges + 3'h1;
    end else if (state == ST_IDLE) begin
      edges <= '0;
    end
  end

  // Divisor counter: one 16-bit count regardless of width select
  // A software write is refused while a measurement runs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      divisor_pair <= '0;
    end else if (state == ST_START && rx_rise) begin
      divisor_pair <= abd_pkg::COUNT_START;
    end else if (state == ST_COUNT && tick && !done) begin
      divisor_pair <= divisor_pair + 16'h0001;
    end else if (wr && sel_div
                 && state == ST_IDLE) begin
      divisor_pair <= wb_dat_i[15:0];
    end
  end

  // Control bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      autobaud_enable <= 1'b0;
      wake_on_break_enable <= 1'b0;
      wide_divisor_select <= 1'b0;
      high_speed_select <= 1'b0;
    end else begin
      if (wr && wb_adr_i == abd_pkg::ADDR_CTRL) begin
        autobaud_enable <= wb_dat_i[abd_pkg::CTRL_AUTOBAUD_ENABLE];
        wake_on_break_enable <= wb_dat_i[abd_pkg::CTRL_WUE];
        wide_divisor_select <= wb_dat_i[abd_pkg::CTRL_WIDE_DIVISOR_SELECT];
        high_speed_select <= wb_dat_i[abd_pkg::CTRL_HIGH_SPEED_SELECT];
      end
      if (done) begin
        autobaud_enable <= 1'b0;
        wake_on_break_enable <= 1'b0;
      end
    end
  end

  // Overflow bit: set wins over a software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      autobaud_overflow <= 1'b0;
    end else if (ovf_evt) begin
      autobaud_overflow <= 1'b1;
    end else if (wr && wb_adr_i == abd_pkg::ADDR_CTRL
                 && !wb_dat_i[abd_pkg::CTRL_OVF]) begin
      autobaud_overflow <= 1'b0;
    end
  end

  // Idle status: low from the enable write until the fifth rise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      receive_idle <= 1'b1;
    end else if (done || abd_stop) begin
      receive_idle <= 1'b1;
    end else if (abd_go) begin
      receive_idle <= 1'b0;
    end
  end

  // Receiver hold spans the same window
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_hold_idle_o <= 1'b0;
    end else if (done || abd_stop) begin
      rx_hold_idle_o <= 1'b0;
    end else if (abd_go) begin
      rx_hold_idle_o <= 1'b1;
    end
  end

  // Receive flag: set wins over the clear by a data read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      receive_flag <= 1'b0;
    end else if (done || ovf_evt) begin
      receive_flag <= 1'b1;
    end else if (clr_flag) begin
      receive_flag <= 1'b0;
    end
  end

  // Data register holds no character during calibration
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      receive_data_reg <= '0;
    end else if (done) begin
      receive_data_reg <= 8'h00;
    end
  end

  // Interrupt mask, above the status bits in the same word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= '0;
    end else if (wr && wb_adr_i == abd_pkg::ADDR_IRQ_MASK) begin
      irq_mask <= wb_dat_i[2*abd_pkg::IRQ_W-1:abd_pkg::IRQ_W];
    end
  end

  // Per-event sticky status: write one to clear, the event wins
  assign irq_evt[abd_pkg::IRQ_RX] = done || ovf_evt;
  assign irq_evt[abd_pkg::IRQ_OVF] = ovf_evt;
  for (genvar b = 0; b < abd_pkg::IRQ_W; b++) begin : g_irq_bit
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        irq_stat[b] <= 1'b0;
      end else if (irq_evt[b]) begin
        irq_stat[b] <= 1'b1;
      end else if (wr && sel_stat && wb_dat_i[b]) begin
        irq_stat[b] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  // Read mux; unmapped addresses read zero and still acknowledge
  always_comb begin
    next_rd_data = '0;
    unique case (wb_adr_i)
      abd_pkg::ADDR_CTRL: begin
        next_rd_data = {26'h0, receive_idle, autobaud_overflow,
          high_speed_select, wide_divisor_select, wake_on_break_enable,
          autobaud_enable};
      end
      abd_pkg::ADDR_DIV: begin
        next_rd_data = {16'h0, divisor_pair};
      end
      abd_pkg::ADDR_RXDATA: begin
        next_rd_data = {23'h0, receive_flag, receive_data_reg};
      end
      abd_pkg::ADDR_IRQ_STAT: begin
        next_rd_data = {28'h0, irq_mask, irq_stat};
      end
      default: begin
        next_rd_data = '0;
      end
    endcase
  end

  // Registered so that read data stands with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (rd) begin
      wb_dat_o <= next_rd_data;
    end
  end

  logic unused;
  assign unused = rx_level ^ rx_fall;
endmodule // uart_auto_baud_detect
`default_nettype wire

// File: test/abd_checker_sva.sv
// Purpose: Port-level assertions for the auto-baud detector
// Assumes: One clock domain, synchronous active-high reset
// Notes: Bound to the top module after endmodule
`timescale 1ns/1ps
`default_nettype none
module abd_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rx_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic rx_hold_idle_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic req;
  logic wr_en;
  assign req = wb_cyc_i && wb_stb_i;
  assign wr_en = req && wb_we_i && wb_sel_i[0] && wb_dat_i[0] &&
                 wb_adr_i == abd_pkg::ADDR_CTRL;
  ack_after_req_a: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(req && !wb_ack_o))
    else $error("ack without request");
  hold_start_a: assert property (wr_en && !wb_ack_o |-> ##[1:3] rx_hold_idle_o)
    else $error("enable write did not hold receiver idle");
  hold_cause_a: assert property ($rose(rx_hold_idle_o) |->
    $past(wr_en) || $past(wr_en, 2))
    else $error("receiver held idle without enable write");
  hold_min_a: assert property ($rose(rx_hold_idle_o) |=> rx_hold_idle_o[*8])
    else $error("measurement ended at once");
  hold_quiet_a: assert property (rx_hold_idle_o && !rx_i && !wb_cyc_i
    |=> rx_hold_idle_o)
    else $error("measurement ended while line low");
  hold_end_a: assert property ($fell(rx_hold_idle_o) |->
    rx_i && $past(rx_i, 2))
    else $error("measurement ended without synced rise");
endmodule // abd_checker
bind uart_auto_baud_detect abd_checker i_abd_checker (.clk_i, .rst_i,
  .rx_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_ack_o, .rx_hold_idle_o);
`default_nettype wire

// File: test/sync_sender.sv
// Purpose: Remote transmitter sending an optional break and 55h
// Assumes: Line idles high between frames
// Notes: Bit time given in system clocks
`timescale 1ns/1ps
`default_nettype none
module sync_sender (
  input wire logic clk_i,
  output logic rx_o
);
  initial rx_o = 1'b1;
  task automatic send(input int bc, input logic brk);
    logic [9:0] f;
    f = {1'b1, 8'h55, 1'b0};
    if (brk) begin
      rx_o <= 1'b0;
      repeat (13 * bc) @(posedge clk_i);
      rx_o <= 1'b1;
      repeat (2 * bc) @(posedge clk_i);
    end
    for (int i = 0; i < 10; i++) begin
      rx_o <= f[i];
      repeat (bc) @(posedge clk_i);
    end
  endtask
endmodule // sync_sender
`default_nettype wire

// File: test/uart_auto_baud_detect_tb.sv
// Purpose: Self-checking bench for the auto-baud detector
// Assumes: Classic Wishbone master, one remote sender model
// Notes: Counts may differ by one from prescaler phase
`timescale 1ns/1ps
`default_nettype none
module uart_auto_baud_detect_tb;
  logic clk_i, rst_i, cyc, stb, we, ack, hold, irq;
  logic [3:0] adr, sel;
  logic [31:0] wdat, rdat, dat_o;
  wire logic rx;
  int fail_count, checks_done;
  sync_sender i_sync_sender (.clk_i(clk_i), .rx_o(rx));
  uart_auto_baud_detect i_uart_auto_baud_detect (.clk_i(clk_i),
    .rst_i(rst_i), .rx_i(rx), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .rx_hold_idle_o(hold), .irq_o(irq));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
    if (n == 50) begin
      fail_count++;
      give_verdict();
    end
  endtask
  // Mode bits: enable, wake, wide, fast; bit time in clocks
  task automatic calibrate(input logic [3:0] mode, input int bc,
                           input logic brk);
    int pre, e, n;
    pre = (mode[2] && mode[3]) ? 32 : (mode[2] || mode[3]) ? 128 : 512;
    e = 1 + 8 * bc / pre;
    bus(1'b1, abd_pkg::ADDR_CTRL, {28'h0, mode});
    check({31'h0, hold}, 32'h1);
    bus(1'b0, abd_pkg::ADDR_CTRL, 32'h0);
    check({30'h0, rdat[5], rdat[0]}, 32'h1);
    bus(1'b1, abd_pkg::ADDR_DIV, 32'h0000_ffff);
    i_sync_sender.send(bc, brk);
    for (n = 0; n < 20 && hold !== 1'b0; n++) @(posedge clk_i);
    check({31'h0, hold}, 32'h0);
    bus(1'b0, abd_pkg::ADDR_CTRL, 32'h0);
    check({30'h0, rdat[5], rdat[0]}, 32'h2);
    bus(1'b0, abd_pkg::ADDR_DIV, 32'h0);
    check(32'(rdat[15:0] >= e - 1 && rdat[15:0] <= e + 1), 32'h1);
    check({24'h0, rdat[15:8]}, 32'h0);
    check({31'h0, irq}, 32'h1);
    bus(1'b0, abd_pkg::ADDR_RXDATA, 32'h0);
    check({31'h0, rdat[8]}, 32'h1);
    bus(1'b0, abd_pkg::ADDR_RXDATA, 32'h0);
    check({31'h0, rdat[8]}, 32'h0);
    bus(1'b1, abd_pkg::ADDR_CTRL, {28'h0, mode & 4'hc});
    check({31'h0, irq}, 32'h1);
    bus(1'b0, abd_pkg::ADDR_IRQ_STAT, 32'h0);
    check({31'h0, rdat[0]}, 32'h1);
    bus(1'b1, abd_pkg::ADDR_IRQ_STAT, 32'h0000_000f);
    bus(1'b0, abd_pkg::ADDR_IRQ_STAT, 32'h0);
    check({30'h0, rdat[1:0]}, 32'h0);
    check({31'h0, irq}, 32'h0);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    fail_count = 0;
    checks_done = 0;
    rst_i = 1'b1;
    {cyc, stb, we} = 3'h0;
    adr = 4'h0;
    sel = 4'hf;
    wdat = 32'h0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, abd_pkg::ADDR_CTRL, 32'h0);
    check({27'h0, rdat[4:0]}, 32'h0);
    check({30'h0, hold, irq}, 32'h0);
    bus(1'b1, abd_pkg::ADDR_IRQ_MASK, 32'h0000_000c);
    bus(1'b0, abd_pkg::ADDR_IRQ_STAT, 32'h0);
    check({28'h0, rdat[3:0]}, 32'hc);
    // Bit times kept inside each prescaler's measurable range
    calibrate(4'hd, 320, 1'b0);
    calibrate(4'h5, 512, 1'b0);
    calibrate(4'h9, 512, 1'b0);
    calibrate(4'h1, 1024, 1'b0);
    calibrate(4'hf, 320, 1'b1);
    give_verdict();
  end
endmodule // uart_auto_baud_detect_tb
`default_nettype wire
